// ---- logic/csrr_defines.vh ----
// Constants for the clock, sync and range register bank.
`ifndef CSRR_DEFINES_VH
`define CSRR_DEFINES_VH
`define CSRR_ADDR_W          12
`define CSRR_OFS_CLK_ONE     12'h02A
`define CSRR_OFS_CLK_TWO     12'h02B
`define CSRR_OFS_POS_0       12'h02C
`define CSRR_OFS_POS_1       12'h02D
`define CSRR_OFS_POS_2       12'h02E
`define CSRR_OFS_FSA_0       12'h030
`define CSRR_OFS_FSA_1       12'h031
`define CSRR_OFS_FSB_0       12'h032
`define CSRR_OFS_FSB_1       12'h033
`define CSRR_RST_CLK_ONE     8'h00
`define CSRR_RST_CLK_TWO     8'h11
`define CSRR_RST_FS          16'hA000
`define CSRR_BIT_POL_FLIP    0
`define CSRR_BIT_SYNC_PECL   1
`define CSRR_BIT_DEV_PECL    2
`define CSRR_BIT_LSB_EN      3
`define CSRR_BIT_DELAY_LO    0
`define CSRR_BIT_DELAY_HI    1
`define CSRR_BIT_NOISE       2
`define CSRR_BIT_GAIN        4
`define CSRR_DECIM_BYPASS    1'b1
`define CSRR_SMP_W           12
`endif

// ---- logic/csrr_byte_reg.v ----
// One byte of writable register storage with its own reset value.
`timescale 1ns/10ps
`default_nettype none
module csrr_byte_reg #(
	parameter [7:0] RESET_VAL = 8'h00
) (
	input  wire       clk_in,
	input  wire       rst_n_in,
	input  wire       wr_en_in,
	input  wire [7:0] wdata_in,
	output wire [7:0] value_out
);
	reg [7:0] value_q;

	// Every bit, reserved ones included, stores what was written.
	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			value_q <= RESET_VAL;
		end else if (wr_en_in) begin
			value_q <= wdata_in;
		end
	end

	assign value_out = value_q;
endmodule
`default_nettype wire

// ---- logic/csrr_regs.v ----
// Clock control, sync edge position and full-scale range register bank.
`timescale 1ns/10ps
`default_nettype none
`include "csrr_defines.vh"
module csrr_regs (
	input  wire                     clk_in,
	input  wire                     rst_n_in,
	input  wire                     wr_en_in,
	input  wire [`CSRR_ADDR_W-1:0]  addr_in,
	input  wire [7:0]               wdata_in,
	output reg  [7:0]               rdata_out,
	input  wire [23:0]              edge_position_in,
	input  wire                     sync_level_in,
	input  wire                     sample_marker_enable_in,
	input  wire                     decim_bypass_in,
	input  wire [`CSRR_SMP_W-1:0]   sample_in,
	output reg  [`CSRR_SMP_W-1:0]   sample_out,
	output wire                     sync_aligned_out,
	output wire                     device_clock_dc_pecl_mode_out,
	output wire                     sync_input_dc_pecl_mode_out,
	output wire                     sysref_on_lsb_enable_out,
	output wire                     clock_converter_gain_out,
	output wire                     supply_noise_suppress_out,
	output wire [1:0]               sample_clock_delay_out,
	output wire [15:0]              full_scale_input_a_out,
	output wire [15:0]              full_scale_input_b_out
);
	localparam NREG = 6;

	// Byte register map: index to address, reset value.
	function [`CSRR_ADDR_W-1:0] reg_addr(input integer i);
		begin
			case (i)
				0:       reg_addr = `CSRR_OFS_CLK_ONE;
				1:       reg_addr = `CSRR_OFS_CLK_TWO;
				2:       reg_addr = `CSRR_OFS_FSA_0;
				3:       reg_addr = `CSRR_OFS_FSA_1;
				4:       reg_addr = `CSRR_OFS_FSB_0;
				default: reg_addr = `CSRR_OFS_FSB_1;
			endcase
		end
	endfunction

	// The 16-bit range reset is split into bytes by part-select, never by a wide shift.
	function [7:0] reg_reset(input integer i);
		reg [15:0] fs;
		begin
			fs = `CSRR_RST_FS;
			case (i)
				0:       reg_reset = `CSRR_RST_CLK_ONE;
				1:       reg_reset = `CSRR_RST_CLK_TWO;
				2:       reg_reset = fs[7:0];
				3:       reg_reset = fs[15:8];
				4:       reg_reset = fs[7:0];
				default: reg_reset = fs[15:8];
			endcase
		end
	endfunction

	wire [8*NREG-1:0] bytes;

	// Storage for every writable byte; position status has none, so its writes are lost.
	genvar g;
	generate
		for (g = 0; g < NREG; g = g + 1) begin : g_reg
			csrr_byte_reg #(
				.RESET_VAL (reg_reset(g))
			) u_byte (
				.clk_in    (clk_in),
				.rst_n_in  (rst_n_in),
				.wr_en_in  (wr_en_in && (addr_in == reg_addr(g))),
				.wdata_in  (wdata_in),
				.value_out (bytes[8*g +: 8])
			);
		end
	endgenerate

	wire [7:0] ctl_one = bytes[7:0];
	wire [7:0] ctl_two = bytes[15:8];

	// Field decode of the two clock control bytes, and the two 16-bit range words.
	assign sync_input_dc_pecl_mode_out   = ctl_one[`CSRR_BIT_SYNC_PECL];
	assign device_clock_dc_pecl_mode_out = ctl_one[`CSRR_BIT_DEV_PECL];
	assign sysref_on_lsb_enable_out      = ctl_one[`CSRR_BIT_LSB_EN];
	assign clock_converter_gain_out      = ctl_two[`CSRR_BIT_GAIN];
	assign supply_noise_suppress_out     = ctl_two[`CSRR_BIT_NOISE];
	assign sample_clock_delay_out        =
		ctl_two[`CSRR_BIT_DELAY_HI:`CSRR_BIT_DELAY_LO];
	assign full_scale_input_a_out        = bytes[31:16];
	assign full_scale_input_b_out        = bytes[47:32];

	// Polarity flip is plain logic so alignment sees it the same cycle.
	wire sync_aligned = sync_level_in ^ ctl_one[`CSRR_BIT_POL_FLIP];
	assign sync_aligned_out = sync_aligned;

	// The marker only applies in bypass mode; decimated samples would lose it anyway.
	wire lsb_swap = ctl_one[`CSRR_BIT_LSB_EN] && sample_marker_enable_in
		&& (decim_bypass_in == `CSRR_DECIM_BYPASS);

	// Registered sample path with optional sync level on the LSB.
	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			sample_out <= {`CSRR_SMP_W{1'b0}};
		end else if (lsb_swap) begin
			sample_out <= {sample_in[`CSRR_SMP_W-1:1], sync_aligned};
		end else begin
			sample_out <= sample_in;
		end
	end

	// Read mux; position bytes come straight from the detector, unmapped reads zero.
	always @* begin
		case (addr_in)
			`CSRR_OFS_CLK_ONE: rdata_out = ctl_one;
			`CSRR_OFS_CLK_TWO: rdata_out = ctl_two;
			`CSRR_OFS_POS_0:   rdata_out = edge_position_in[7:0];
			`CSRR_OFS_POS_1:   rdata_out = edge_position_in[15:8];
			`CSRR_OFS_POS_2:   rdata_out = edge_position_in[23:16];
			`CSRR_OFS_FSA_0:   rdata_out = bytes[23:16];
			`CSRR_OFS_FSA_1:   rdata_out = bytes[31:24];
			`CSRR_OFS_FSB_0:   rdata_out = bytes[39:32];
			`CSRR_OFS_FSB_1:   rdata_out = bytes[47:40];
			default:           rdata_out = 8'h00;
		endcase
	end
endmodule
`default_nettype wire

// ---- test/csrr_regs_props.sv ----
// Assertions for the clock, sync and range register bank.
`timescale 1ns/10ps
`default_nettype none
module csrr_regs_props (
	input wire logic clk_in, rst_n_in, wr_en_in, sync_level_in, sync_aligned_out,
	input wire logic sample_marker_enable_in, decim_bypass_in, sysref_on_lsb_enable_out,
	input wire logic clock_converter_gain_out, supply_noise_suppress_out,
	input wire logic [11:0] addr_in, sample_in, sample_out,
	input wire logic [7:0] wdata_in, rdata_out,
	input wire logic [23:0] edge_position_in,
	input wire logic [1:0] sample_clock_delay_out,
	input wire logic [15:0] full_scale_input_a_out, full_scale_input_b_out
);
	// One clock domain, so every check shares the clock and stays quiet in reset.
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	a_reset_vals: assert property ($rose(rst_n_in) |->
		clock_converter_gain_out && sample_clock_delay_out == 2'h1 &&
		full_scale_input_b_out == 16'hA000) else $error("bad reset value");
	a_lsb_swap: assert property ($past(rst_n_in) |-> sample_out[0] ==
		($past(sysref_on_lsb_enable_out && sample_marker_enable_in && decim_bypass_in) ?
		$past(sync_aligned_out) : $past(sample_in[0]))) else $error("bad sample lsb");
	a_pol_flip: assert property (wr_en_in && addr_in == 12'h02A |=>
		sync_aligned_out == (sync_level_in ^ $past(wdata_in[0]))) else $error("bad polarity");
	a_lsb_enable: assert property (wr_en_in && addr_in == 12'h02A |=>
		sysref_on_lsb_enable_out == $past(wdata_in[3])) else $error("bad lsb enable");
	a_ctl_two_wr: assert property (wr_en_in && addr_in == 12'h02B |=>
		{clock_converter_gain_out, supply_noise_suppress_out, sample_clock_delay_out} ==
		{$past(wdata_in[4]), $past(wdata_in[2:0])}) else $error("bad control two");
	a_fsa_low: assert property (wr_en_in && addr_in == 12'h030 |=>
		full_scale_input_a_out[7:0] == $past(wdata_in)) else $error("bad range a");
	a_fsb_high: assert property (wr_en_in && addr_in == 12'h033 |=>
		full_scale_input_b_out[15:8] == $past(wdata_in)) else $error("bad range b");
	a_pos_read: assert property (addr_in == 12'h02E |->
		rdata_out == edge_position_in[23:16]) else $error("bad position");
endmodule
bind csrr_regs csrr_regs_props i_props (.*);
`default_nettype wire

// ---- test/tb.sv ----
// Self-checking bench for the clock, sync and range register bank.
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic clk_in = 0, rst_n_in = 0, wr_en_in = 0, sync_level_in = 0, sync_aligned_out;
	logic sample_marker_enable_in = 0, decim_bypass_in = 0, sysref_on_lsb_enable_out;
	logic device_clock_dc_pecl_mode_out, sync_input_dc_pecl_mode_out;
	logic clock_converter_gain_out, supply_noise_suppress_out;
	logic [11:0] addr_in = 0, sample_in = 0, sample_out;
	logic [7:0] wdata_in = 0, rdata_out;
	logic [23:0] edge_position_in = 0;
	logic [1:0] sample_clock_delay_out;
	logic [15:0] full_scale_input_a_out, full_scale_input_b_out;
	int fail_count = 0, n_checks = 0;
	csrr_regs i_dut (.*);
	// Free-running clock of 10 ns period.
	always #5 clk_in = ~clk_in;
	// Counts a comparison and reports a mismatch at once.
	task automatic cmp(string nm, logic [23:0] e, g);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask
	// The strobe drops at the next edge, so back-to-back writes never collide.
	task automatic wr(logic [11:0] a, logic [7:0] d);
		@(posedge clk_in);
		wr_en_in <= 1'b1;
		addr_in <= a;
		wdata_in <= d;
		@(posedge clk_in);
		wr_en_in <= 1'b0;
	endtask
	// Read data is combinational, so it is sampled just after the address lands.
	task automatic rd(logic [11:0] a, logic [7:0] e);
		@(posedge clk_in);
		addr_in <= a;
		#1 cmp("rdata_out", e, rdata_out);
	endtask
	// Drives one sample and checks the registered copy one edge later.
	task automatic smp(logic mk, sl, by, logic [11:0] e);
		@(posedge clk_in);
		sample_marker_enable_in <= mk;
		sync_level_in <= sl;
		decim_bypass_in <= by;
		sample_in <= 12'hFFE;
		@(posedge clk_in);
		#1 cmp("sample_out", e, sample_out);
	endtask
	// Prints the counts and the verdict, then ends the run.
	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// Main sequence of register and sample-path scenarios.
	initial begin
		repeat (20) @(posedge clk_in);
		rst_n_in <= 1'b1;
		rd(12'h02A, 8'h00);
		rd(12'h02B, 8'h11);
		rd(12'h031, 8'hA0);
		wr(12'h02A, 8'hFF);
		rd(12'h02A, 8'hFF);
		cmp("device_clock_dc_pecl_mode_out", 1, device_clock_dc_pecl_mode_out);
		cmp("sync_input_dc_pecl_mode_out", 1, sync_input_dc_pecl_mode_out);
		cmp("sysref_on_lsb_enable_out", 1, sysref_on_lsb_enable_out);
		wr(12'h02B, 8'hEE);
		rd(12'h02B, 8'hEE);
		cmp("clock_converter_gain_out", 0, clock_converter_gain_out);
		cmp("supply_noise_suppress_out", 1, supply_noise_suppress_out);
		cmp("sample_clock_delay_out", 2'h2, sample_clock_delay_out);
		wr(12'h030, 8'h5A);
		wr(12'h031, 8'hFF);
		wr(12'h033, 8'h20);
		rd(12'h033, 8'h20);
		cmp("range_a", 16'hFF5A, full_scale_input_a_out);
		cmp("range_b", 16'h2000, full_scale_input_b_out);
		@(posedge clk_in) edge_position_in <= 24'h5A3C96;
		wr(12'h02C, 8'h00);
		rd(12'h02C, 8'h96);
		rd(12'h02E, 8'h5A);
		wr(12'h02F, 8'h55);
		rd(12'h02F, 8'h00);
		smp(1'b1, 1'b0, 1'b1, 12'hFFF);
		cmp("sync_aligned_out", 1, sync_aligned_out);
		smp(1'b0, 1'b0, 1'b1, 12'hFFE);
		smp(1'b1, 1'b0, 1'b0, 12'hFFE);
		// A second reset in mid-run must bring every written byte back to its reset value.
		@(posedge clk_in) rst_n_in <= 1'b0;
		@(posedge clk_in) rst_n_in <= 1'b1;
		rd(12'h02A, 8'h00);
		rd(12'h02B, 8'h11);
		rd(12'h030, 8'h00);
		rd(12'h033, 8'hA0);
		cmp("sample_clock_delay_out", 2'h1, sample_clock_delay_out);
		stop_test();
	end
endmodule
`default_nettype wire
